// file: logic/ccpu_defines.svh
/*
 * Constants of the compare/PWM unit: register offsets, field positions,
 * reset values and mode codes.
 * Assumes inclusion by bare name from the unit's design file.
 */
`ifndef CCPU_DEFINES_SVH
`define CCPU_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CCPU_OFF_VALUE_LOW 3'h0
`define CCPU_OFF_VALUE_HIGH 3'h1
`define CCPU_OFF_CONTROL 3'h2
`define CCPU_OFF_CONFIG 3'h3
`define CCPU_OFF_STATUS 3'h4
`define CCPU_OFF_PIN 3'h5

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CCPU_CTL_MODE_LSB 0
`define CCPU_CTL_MODE_MSB 3
`define CCPU_CTL_DUTY_LSB 4
`define CCPU_CTL_DUTY_MSB 5
`define CCPU_CFG_CMP_SEL 0
`define CCPU_CFG_PWM_SEL 1
`define CCPU_CFG_MATCH_EN 2
`define CCPU_STS_MATCH 0
`define CCPU_PIN_DATA 0
`define CCPU_PIN_DIR 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CCPU_RST_BYTE 8'h00
`define CCPU_RST_CONFIG 3'h0
`define CCPU_RST_DIR 1'b1

// ----------------------------------------------------------------------
// Mode select codes
// ----------------------------------------------------------------------
`define CCPU_MODE_OFF 4'h0
`define CCPU_MODE_TOGGLE 4'h2
`define CCPU_MODE_SET 4'h8
`define CCPU_MODE_CLR 4'h9
`define CCPU_MODE_EVENT 4'ha
`define CCPU_MODE_TRIG 4'hb

`endif

// file: logic/ccpu_pkg.sv
/*
 * Types of the compare/PWM unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ccpu_pkg;

   // -------------------------------------------------------------------
   // Decoded operating kind of the unit
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      CCPU_KIND_OFF = 3'h0,
      CCPU_KIND_TOGGLE = 3'h1,
      CCPU_KIND_SET = 3'h3,
      CCPU_KIND_CLR = 3'h2,
      CCPU_KIND_EVENT = 3'h6,
      CCPU_KIND_TRIG = 3'h7,
      CCPU_KIND_PWM = 3'h5,
      CCPU_KIND_OTHER = 3'h4
   } ccpu_kind_t;

endpackage

// file: logic/ccpu_unit.sv
/*
 * One compare/PWM unit: compare against a selected 16-bit timer, PWM
 * against a selected 8-bit period timer, and its register port.
 * Assumes the timers live outside on the same clock and deliver their
 * counts, increment strobes and prescaler low bits synchronously.
 */
// Behaviour
// [RQ1] Compare value against selected timer every cycle
// [RQ2] Match sets flag with pin action together
// [RQ3] Mode 1010: pin untouched, only event raised
// [RQ4] Zero control write forces unit latch low
// [RQ5] Software runs compare timer synchronously
// [RQ6] Software zeroes control before changing prescaler
// [RQ7] Software clears direction bit for output
// [RQ8] PWM output with up to 10-bit duty
// [RQ9] Period set by period limit register
// [RQ10] Timer clears on increment after limit match
// [RQ11] Pin set at period start unless duty zero
// [RQ12] Rollover copies duty into high register, latch
// [RQ13] Postscaler does not affect PWM period
// [RQ14] Duty is value low plus control bits 5:4
// [RQ15] High time is duty times prescaled clock
// [RQ16] Duty writes take effect at next rollover
// [RQ17] High register read-only in PWM mode
// [RQ18] Low duty bits in hidden 2-bit latch
// [RQ19] Decode compare modes 0010,1000,1001,1010,1011
// [RQ20] Mode 0000 resets unit; 11xx is PWM
// [RQ21] Pin cleared when duty equals extended count
// [RQ22] Duty beyond period keeps pin high
// [RQ23] Timers are inputs, not implemented here
`timescale 1ns/100ps
`include "ccpu_defines.svh"

module ccpu_unit #(
   parameter int TIMER_W = 16,
   parameter int PWM_W = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [7:0] regRdData,
   input wire logic [TIMER_W-1:0] compareTimerA,
   input wire logic [TIMER_W-1:0] compareTimerB,
   input wire logic [PWM_W-1:0] pwmTimerA,
   input wire logic [PWM_W-1:0] pwmTimerB,
   input wire logic [PWM_W-1:0] pwmPeriodLimitA,
   input wire logic [PWM_W-1:0] pwmPeriodLimitB,
   input wire logic pwmTickA,
   input wire logic pwmTickB,
   input wire logic [1:0] pwmFracA,
   input wire logic [1:0] pwmFracB,
   output logic pinOut,
   output logic pinOe,
   output logic matchEventFlag,
   output logic matchRequest,
   output logic specialTrigger
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   logic [7:0] valueLow_reg, valueLow_next;
   logic [7:0] valueHigh_reg, valueHigh_next;
   logic [7:0] control_reg, control_next;
   logic [2:0] config_reg, config_next;
   logic flag_reg, flag_next;
   logic portLatch_reg, portLatch_next;
   logic dirBit_reg, dirBit_next;
   logic unitLatch_reg, unitLatch_next;
   logic [1:0] dutyLatch_reg, dutyLatch_next;
   logic matchSeen_reg, matchSeen_next;
   logic [7:0] rdData_reg, rdData_next;
   logic pinOut_reg, pinOut_next;
   logic pinOe_reg, pinOe_next;
   logic trig_reg, trig_next;
   logic req_reg, req_next;

   ccpu_pkg::ccpu_kind_t kind;
   logic isCompare;
   logic [TIMER_W-1:0] cmpTimer;
   logic [PWM_W-1:0] pwmTimer;
   logic [PWM_W-1:0] pwmLimit;
   logic pwmTick;
   logic [1:0] pwmFrac;
   logic cmpMatch;
   logic cmpEdge;
   logic rollover;
   logic dutyMatch;
   logic [PWM_W+1:0] countNext;
   logic wrCtl;
   logic wrHigh;
   logic wrLow;
   logic wrSts;
   logic wrPin;
   logic wrCfg;

   // -------------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------------
   // Decode mode select field
   // [RQ19] compare mode decode
   // [RQ20] off and PWM decode
   always_comb begin
      casez (control_reg[`CCPU_CTL_MODE_MSB:`CCPU_CTL_MODE_LSB])
         `CCPU_MODE_OFF: kind = ccpu_pkg::CCPU_KIND_OFF;
         `CCPU_MODE_TOGGLE: kind = ccpu_pkg::CCPU_KIND_TOGGLE;
         `CCPU_MODE_SET: kind = ccpu_pkg::CCPU_KIND_SET;
         `CCPU_MODE_CLR: kind = ccpu_pkg::CCPU_KIND_CLR;
         `CCPU_MODE_EVENT: kind = ccpu_pkg::CCPU_KIND_EVENT;
         `CCPU_MODE_TRIG: kind = ccpu_pkg::CCPU_KIND_TRIG;
         4'b11??: kind = ccpu_pkg::CCPU_KIND_PWM;
         default: kind = ccpu_pkg::CCPU_KIND_OTHER;
      endcase
   end

   // Timer selection and comparators
   // [RQ23] timers taken as inputs
   always_comb begin
      isCompare = (kind == ccpu_pkg::CCPU_KIND_TOGGLE) ||
         (kind == ccpu_pkg::CCPU_KIND_SET) ||
         (kind == ccpu_pkg::CCPU_KIND_CLR) ||
         (kind == ccpu_pkg::CCPU_KIND_EVENT) ||
         (kind == ccpu_pkg::CCPU_KIND_TRIG);
      cmpTimer = config_reg[`CCPU_CFG_CMP_SEL] ? compareTimerB
         : compareTimerA;
      pwmTimer = config_reg[`CCPU_CFG_PWM_SEL] ? pwmTimerB : pwmTimerA;
      pwmLimit = config_reg[`CCPU_CFG_PWM_SEL] ? pwmPeriodLimitB
         : pwmPeriodLimitA;
      pwmTick = config_reg[`CCPU_CFG_PWM_SEL] ? pwmTickB : pwmTickA;
      pwmFrac = config_reg[`CCPU_CFG_PWM_SEL] ? pwmFracB : pwmFracA;
      // [RQ1] full-width equality
      cmpMatch = ({valueHigh_reg, valueLow_reg} == cmpTimer);
      cmpEdge = isCompare && cmpMatch && !matchSeen_reg;
      // [RQ9] period from limit only
      // [RQ13] no postscaler term
      rollover = (kind == ccpu_pkg::CCPU_KIND_PWM) && pwmTick &&
         (pwmTimer == pwmLimit);
      // [RQ21] extended count compare, one count ahead so the
      // registered pin falls as the count reaches the duty
      countNext = {pwmTimer, pwmFrac} + (PWM_W+2)'(1);
      dutyMatch = (countNext == {valueHigh_reg, dutyLatch_reg});
   end

   // Register write decode
   always_comb begin
      wrLow = regWrStb && (regAddr == `CCPU_OFF_VALUE_LOW);
      wrHigh = regWrStb && (regAddr == `CCPU_OFF_VALUE_HIGH);
      wrCtl = regWrStb && (regAddr == `CCPU_OFF_CONTROL);
      wrCfg = regWrStb && (regAddr == `CCPU_OFF_CONFIG);
      wrSts = regWrStb && (regAddr == `CCPU_OFF_STATUS);
      wrPin = regWrStb && (regAddr == `CCPU_OFF_PIN);
   end

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   // Compare, PWM and register port behaviour
   always_comb begin
      valueLow_next = valueLow_reg;
      valueHigh_next = valueHigh_reg;
      control_next = control_reg;
      config_next = config_reg;
      flag_next = flag_reg;
      portLatch_next = portLatch_reg;
      dirBit_next = dirBit_reg;
      unitLatch_next = unitLatch_reg;
      dutyLatch_next = dutyLatch_reg;
      matchSeen_next = isCompare && cmpMatch;
      trig_next = 1'b0;
      rdData_next = `CCPU_RST_BYTE;

      // [RQ2] flag and pin action together
      if (cmpEdge) begin
         case (kind)
            ccpu_pkg::CCPU_KIND_TOGGLE: unitLatch_next = !unitLatch_reg;
            ccpu_pkg::CCPU_KIND_SET: unitLatch_next = 1'b1;
            ccpu_pkg::CCPU_KIND_CLR: unitLatch_next = 1'b0;
            ccpu_pkg::CCPU_KIND_TRIG: trig_next = 1'b1;
            // [RQ3] event only, pin untouched
            default: unitLatch_next = unitLatch_reg;
         endcase
      end

      // [RQ10] new period on tick after limit
      if (rollover) begin
         // [RQ12] double-buffer transfer
         // [RQ16] new duty used from here
         valueHigh_next = valueLow_reg;
         // [RQ18] hidden low duty latch
         dutyLatch_next = control_reg[`CCPU_CTL_DUTY_MSB:`CCPU_CTL_DUTY_LSB];
         // [RQ11] set pin unless duty zero
         // [RQ14] duty from low register and bits 5:4
         unitLatch_next = ({valueLow_reg, control_reg[
            `CCPU_CTL_DUTY_MSB:`CCPU_CTL_DUTY_LSB]} != 10'h000);
      end else if ((kind == ccpu_pkg::CCPU_KIND_PWM) && dutyMatch) begin
         // [RQ8] high time ends on duty match
         // [RQ15] duty counts prescaled clock
         // [RQ22] never matches past the limit
         unitLatch_next = 1'b0;
      end

      // Software writes
      if (wrLow) begin
         valueLow_next = regWrData;
      end
      // [RQ17] high register locked in PWM
      if (wrHigh && (kind != ccpu_pkg::CCPU_KIND_PWM)) begin
         valueHigh_next = regWrData;
      end
      if (wrCfg) begin
         config_next = regWrData[2:0];
      end
      if (wrPin) begin
         portLatch_next = regWrData[`CCPU_PIN_DATA];
         dirBit_next = regWrData[`CCPU_PIN_DIR];
      end
      if (wrCtl) begin
         control_next = {2'b00, regWrData[5:0]};
         case (regWrData[`CCPU_CTL_MODE_MSB:`CCPU_CTL_MODE_LSB])
            // [RQ4] zero forces latch low
            // [RQ20] off resets the unit
            `CCPU_MODE_OFF: begin
               unitLatch_next = 1'b0;
               dutyLatch_next = 2'b00;
               matchSeen_next = 1'b0;
            end
            `CCPU_MODE_SET: unitLatch_next = 1'b0;
            `CCPU_MODE_CLR: unitLatch_next = 1'b1;
            default: unitLatch_next = unitLatch_next;
         endcase
      end

      // Sticky flag, a new match beats the clear
      flag_next = cmpEdge ||
         (flag_reg && !(wrSts && regWrData[`CCPU_STS_MATCH]));

      // Read data, valid the cycle after the strobe
      if (regRdStb) begin
         case (regAddr)
            `CCPU_OFF_VALUE_LOW: rdData_next = valueLow_reg;
            `CCPU_OFF_VALUE_HIGH: rdData_next = valueHigh_reg;
            `CCPU_OFF_CONTROL: rdData_next = control_reg;
            `CCPU_OFF_CONFIG: rdData_next = {5'h00, config_reg};
            `CCPU_OFF_STATUS: rdData_next = {7'h00, flag_reg};
            `CCPU_OFF_PIN: rdData_next = {6'h00, dirBit_reg, portLatch_reg};
            default: rdData_next = `CCPU_RST_BYTE;
         endcase
      end
   end

   // Pin and request outputs follow the next state
   // [RQ7] direction bit gates the driver
   always_comb begin
      case (control_next[`CCPU_CTL_MODE_MSB:`CCPU_CTL_MODE_LSB])
         `CCPU_MODE_TOGGLE, `CCPU_MODE_SET, `CCPU_MODE_CLR,
         4'hc, 4'hd, 4'he, 4'hf: pinOut_next = unitLatch_next;
         default: pinOut_next = portLatch_next;
      endcase
      pinOe_next = !dirBit_next;
      // [RQ3] request only when enabled
      req_next = flag_next && config_next[`CCPU_CFG_MATCH_EN];
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   // State registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         valueLow_reg <= `CCPU_RST_BYTE;
         valueHigh_reg <= `CCPU_RST_BYTE;
         control_reg <= `CCPU_RST_BYTE;
         config_reg <= `CCPU_RST_CONFIG;
         flag_reg <= 1'b0;
         portLatch_reg <= 1'b0;
         dirBit_reg <= `CCPU_RST_DIR;
         unitLatch_reg <= 1'b0;
         dutyLatch_reg <= 2'b00;
         matchSeen_reg <= 1'b0;
         rdData_reg <= `CCPU_RST_BYTE;
         pinOut_reg <= 1'b0;
         pinOe_reg <= 1'b0;
         trig_reg <= 1'b0;
         req_reg <= 1'b0;
      end else begin
         valueLow_reg <= valueLow_next;
         valueHigh_reg <= valueHigh_next;
         control_reg <= control_next;
         config_reg <= config_next;
         flag_reg <= flag_next;
         portLatch_reg <= portLatch_next;
         dirBit_reg <= dirBit_next;
         unitLatch_reg <= unitLatch_next;
         dutyLatch_reg <= dutyLatch_next;
         matchSeen_reg <= matchSeen_next;
         rdData_reg <= rdData_next;
         pinOut_reg <= pinOut_next;
         pinOe_reg <= pinOe_next;
         trig_reg <= trig_next;
         req_reg <= req_next;
      end
   end

   // Outputs straight from flip-flops
   assign regRdData = rdData_reg;
   assign pinOut = pinOut_reg;
   assign pinOe = pinOe_reg;
   assign matchEventFlag = flag_reg;
   assign matchRequest = req_reg;
   assign specialTrigger = trig_reg;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   AST_MATCH_FLAG: assert property (@(posedge clk) disable iff (reset) // [RQ1]
      (isCompare && cmpMatch && !matchSeen_reg) |=> matchEventFlag)
      else $error("compare match did not set flag");

   AST_TOGGLE: assert property (@(posedge clk) disable iff (reset) // [RQ2]
      (cmpEdge && kind == ccpu_pkg::CCPU_KIND_TOGGLE && !wrCtl)
      |=> (unitLatch_reg != $past(unitLatch_reg)))
      else $error("toggle mode did not toggle on match");

   AST_EVENT_PIN: assert property (@(posedge clk) disable iff (reset) // [RQ3]
      (kind == ccpu_pkg::CCPU_KIND_EVENT && !regWrStb)
      |=> (pinOut == $past(portLatch_reg)))
      else $error("event mode disturbed the pin");

   AST_ZERO_CTL: assert property (@(posedge clk) disable iff (reset) // [RQ4]
      (wrCtl && regWrData == 8'h00)
      |=> (!unitLatch_reg && pinOut == $past(portLatch_reg)))
      else $error("zero control write left latch high");

   AST_PERIOD_SET: assert property ( // [RQ11]
      @(posedge clk) disable iff (reset)
      (rollover && !wrCtl && {valueLow_reg, control_reg[5:4]} != 10'h000)
      |=> (unitLatch_reg && pinOut))
      else $error("pin not set at period start");

   AST_BUFFER: assert property (@(posedge clk) disable iff (reset) // [RQ12]
      (rollover && !wrCtl)
      |=> (valueHigh_reg == $past(valueLow_reg) &&
         dutyLatch_reg == $past(control_reg[5:4])))
      else $error("duty not transferred at rollover");

   AST_HIGH_RO: assert property (@(posedge clk) disable iff (reset) // [RQ17]
      (kind == ccpu_pkg::CCPU_KIND_PWM && !rollover)
      |=> $stable(valueHigh_reg))
      else $error("high register changed mid period");

   AST_DUTY_CLR: assert property (@(posedge clk) disable iff (reset) // [RQ21]
      (kind == ccpu_pkg::CCPU_KIND_PWM && !rollover && dutyMatch && !wrCtl)
      |=> !unitLatch_reg)
      else $error("pin not cleared on duty match");

   AST_READ_FLAG: assert property (@(posedge clk) disable iff (reset) // [RQ2]
      (regRdStb && regAddr == `CCPU_OFF_STATUS)
      |=> (regRdData == {7'h00, $past(flag_reg)}))
      else $error("status read mismatch");

   AST_OFF_RESET: assert property (@(posedge clk) disable iff (reset) // [RQ20]
      (wrCtl && regWrData[3:0] == `CCPU_MODE_OFF)
      |=> (!unitLatch_reg && dutyLatch_reg == 2'b00 && !matchSeen_reg))
      else $error("mode off did not reset the unit");

   AST_TRIG_OUT: assert property (@(posedge clk) disable iff (reset) // [RQ19]
      (cmpEdge && kind == ccpu_pkg::CCPU_KIND_TRIG) |=> specialTrigger)
      else $error("special trigger missing on match");

   AST_CLR_PIN: assert property (@(posedge clk) disable iff (reset) // [RQ19]
      (cmpEdge && kind == ccpu_pkg::CCPU_KIND_CLR && !wrCtl) |=> !pinOut)
      else $error("clear mode left the pin high");

endmodule

// file: verif/ccpu_pin_model.sv
/*
 * Far-side model: an 8-bit PWM timer with a prescale of four and its
 * two phase bits, plus the unit's pin with a pull-down resistor.
 * Assumes the same clock and reset as the unit it serves.
 */
`timescale 1ns/100ps

module ccpu_pin_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] limit,
   input wire logic pinOut,
   input wire logic pinOe,
   output logic [7:0] timer,
   output logic tick,
   output logic [1:0] frac,
   output logic pinLevel
);

   // ----------------------------------------------------------------
   // Timer and phase bits
   // ----------------------------------------------------------------
   // Synchronous timer, no postscaler
   assign tick = (frac == 2'h3);

   // Phase counts every clock, timer steps on the tick
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         frac <= 2'h0;
         timer <= 8'h00;
      end else begin
         frac <= frac + 2'h1;
         if (tick) begin
            timer <= (timer == limit) ? 8'h00 : timer + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin wire
   // ----------------------------------------------------------------
   // Pull-down when undriven
   assign pinLevel = pinOe ? pinOut : 1'b0;

endmodule

// file: verif/tb_ccpu_unit.sv
/*
 * Self-checking bench of the compare/PWM unit: register reset values,
 * every compare mode, timer select and PWM duty measurements.
 * Assumes the unit, its defines header and the pin model are compiled.
 */
`timescale 1ns/100ps
`include "ccpu_defines.svh"

module tb_ccpu_unit;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWrStb = 1'b0;
   logic regRdStb = 1'b0;
   logic [7:0] regRdData;
   logic [15:0] compareTimerA = 16'h0000;
   logic [15:0] compareTimerB = 16'h0000;
   logic [7:0] pwmTimerA, pwmTimerB;
   logic [7:0] limitA = 8'h07;
   logic [7:0] limitB = 8'h03;
   logic tickA, tickB;
   logic [1:0] fracA, fracB;
   logic pinOut, pinOe, matchEventFlag, matchRequest, specialTrigger;
   logic pinLevel;
   int errors = 0;
   int checkCount = 0;
   int trigCount = 0;
   logic [7:0] rdVal;
   logic [15:0] hiCount;
   logic [3:0] modes [5] = '{4'h8, 4'h2, 4'h9, 4'ha, 4'hb};
   logic preExp [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
   logic postExp [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   logic [7:0] resetExp [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h02, 8'h00};

   // ----------------------------------------------------------------
   // Clock, design and far side
   // ----------------------------------------------------------------
   // Half period of 20 ns
   always #20 clk = ~clk;

   ccpu_unit uut (.clk(clk), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .compareTimerA(compareTimerA),
      .compareTimerB(compareTimerB), .pwmTimerA(pwmTimerA),
      .pwmTimerB(pwmTimerB), .pwmPeriodLimitA(limitA),
      .pwmPeriodLimitB(limitB), .pwmTickA(tickA), .pwmTickB(tickB),
      .pwmFracA(fracA), .pwmFracB(fracB), .pinOut(pinOut),
      .pinOe(pinOe), .matchEventFlag(matchEventFlag),
      .matchRequest(matchRequest), .specialTrigger(specialTrigger));

   ccpu_pin_model modA (.clk(clk), .reset(reset), .limit(limitA),
      .pinOut(pinOut), .pinOe(pinOe), .timer(pwmTimerA), .tick(tickA),
      .frac(fracA), .pinLevel(pinLevel));

   ccpu_pin_model modB (.clk(clk), .reset(reset), .limit(limitB),
      .pinOut(pinOut), .pinOe(pinOe), .timer(pwmTimerB), .tick(tickB),
      .frac(fracB), .pinLevel());

   // Counts trigger pulses seen at each falling edge
   always @(negedge clk) begin
      if (specialTrigger === 1'b1) begin
         trigCount++;
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Compares and reports at once
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge clk);
      regWrStb <= 1'b0;
   endtask

   // One-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge clk);
      regRdStb <= 1'b0;
      @(negedge clk);
      d = regRdData;
   endtask

   // Holds an equal count for three cycles on one compare timer
   task automatic hit(input logic [15:0] t, input bit useB);
      @(posedge clk);
      compareTimerA <= useB ? 16'h0000 : t;
      compareTimerB <= useB ? t : 16'h0000;
      repeat (3) @(posedge clk);
      compareTimerA <= 16'h0000;
      compareTimerB <= 16'h0000;
      repeat (2) @(negedge clk);
   endtask

   // Waits for the rollover cycle of the chosen PWM timer
   task automatic sync(input bit useB);
      int n;
      n = 0;
      @(negedge clk);
      while (!(useB ? (tickB && pwmTimerB == limitB)
            : (tickA && pwmTimerA == limitA)) && n < 200) begin
         @(negedge clk);
         n++;
      end
   endtask

   // Counts high cycles over one whole period after a rollover
   task automatic measure(input bit useB, output logic [15:0] hi);
      int per;
      per = (useB ? int'(limitB) : int'(limitA)) * 4 + 4;
      hi = 16'h0000;
      sync(useB);
      repeat (per) begin
         @(negedge clk);
         hi = hi + {15'h0000, pinLevel};
      end
   endtask

   // Prints the verdict and ends the run
   task automatic end_of_test;
      if (errors == 0 && checkCount > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   // Watchdog well beyond the expected run
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_of_test;
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      for (int a = 0; a < 7; a++) begin
         rd(3'(a), rdVal);
         check({8'h00, rdVal}, {8'h00, resetExp[a]});
      end
      check({15'h0000, pinOe}, 16'h0000);
      wr(`CCPU_OFF_PIN, 8'h01);
      wr(`CCPU_OFF_CONFIG, 8'h04);
      wr(`CCPU_OFF_VALUE_LOW, 8'h34);
      wr(`CCPU_OFF_VALUE_HIGH, 8'h12);
      check({15'h0000, pinOe}, 16'h0001);
      // Each compare mode: preset, lasting equality, one action
      for (int i = 0; i < 5; i++) begin
         wr(`CCPU_OFF_CONTROL, 8'h00);
         wr(`CCPU_OFF_STATUS, 8'h01);
         wr(`CCPU_OFF_CONTROL, {4'h0, modes[i]});
         trigCount = 0;
         repeat (2) @(negedge clk);
         check({15'h0000, pinLevel}, {15'h0000, preExp[i]});
         check({15'h0000, matchEventFlag}, 16'h0000);
         hit(16'h1234, 1'b0);
         check({15'h0000, pinLevel}, {15'h0000, postExp[i]});
         check({15'h0000, matchRequest}, 16'h0001);
         check(trigCount[15:0], (i == 4) ? 16'h0001 : 16'h0000);
         rd(`CCPU_OFF_STATUS, rdVal);
         check({8'h00, rdVal}, 16'h0001);
      end
      // Timer B selected: equality on timer A is ignored
      wr(`CCPU_OFF_CONFIG, 8'h05);
      wr(`CCPU_OFF_STATUS, 8'h01);
      hit(16'h1234, 1'b0);
      check({15'h0000, matchEventFlag}, 16'h0000);
      hit(16'h1234, 1'b1);
      check({15'h0000, matchEventFlag}, 16'h0001);
      // PWM on timer A, 32-cycle period, duty 13
      wr(`CCPU_OFF_CONFIG, 8'h00);
      @(negedge clk);
      check({15'h0000, matchRequest}, 16'h0000);
      wr(`CCPU_OFF_VALUE_LOW, 8'h03);
      wr(`CCPU_OFF_CONTROL, 8'h1c);
      measure(1'b0, hiCount);
      check(hiCount, 16'h000d);
      // High register ignores writes, new duty waits for rollover
      sync(1'b0);
      wr(`CCPU_OFF_VALUE_HIGH, 8'h55);
      wr(`CCPU_OFF_VALUE_LOW, 8'h05);
      rd(`CCPU_OFF_VALUE_HIGH, rdVal);
      check({8'h00, rdVal}, 16'h0003);
      measure(1'b0, hiCount);
      check(hiCount, 16'h0015);
      rd(`CCPU_OFF_VALUE_HIGH, rdVal);
      check({8'h00, rdVal}, 16'h0005);
      // Zero duty keeps the pin low
      wr(`CCPU_OFF_VALUE_LOW, 8'h00);
      wr(`CCPU_OFF_CONTROL, 8'h0c);
      measure(1'b0, hiCount);
      check(hiCount, 16'h0000);
      // Duty beyond the period keeps the pin high
      wr(`CCPU_OFF_VALUE_LOW, 8'h20);
      measure(1'b0, hiCount);
      check(hiCount, 16'h0020);
      // Clearing control drops the unit latch
      wr(`CCPU_OFF_CONTROL, 8'h00);
      wr(`CCPU_OFF_CONTROL, 8'h02);
      repeat (2) @(negedge clk);
      check({15'h0000, pinLevel}, 16'h0000);
      // PWM on timer B, 16-cycle period, duty 10
      wr(`CCPU_OFF_CONFIG, 8'h02);
      wr(`CCPU_OFF_VALUE_LOW, 8'h02);
      wr(`CCPU_OFF_CONTROL, 8'h2c);
      measure(1'b1, hiCount);
      check(hiCount, 16'h000a);
      end_of_test;
   end

endmodule
